// File: bus_mode_pkg.sv
// constants, types and address map of the chip and bus mode decoder
package bus_mode_pkg;

    // physical address width of the cpu
    localparam int ADDR_W = 24;
    // external address bus width and pin counts
    localparam int EXT_ADDR_W  = 19;
    localparam int PORT_OUT_W  = 25;
    localparam int PORT_IO_W   = 16;
    localparam int DATA_W      = 8;
    localparam int CE_N_W      = 4;

    // bus mode encodings, one-hot
    typedef enum logic [2:0] {
        MODE_SINGLE_MAX = 3'h1,
        MODE_EXP_MIN    = 3'h2,
        MODE_EXP_MAX    = 3'h4
    } bus_mode_t;

    // software mode request codes
    localparam logic [1:0] REQ_SINGLE_MAX = 2'h0;
    localparam logic [1:0] REQ_EXP_MIN    = 2'h1;
    localparam logic [1:0] REQ_EXP_MAX    = 2'h2;

    // internal memory ranges
    localparam logic [23:0] IROM_LO   = 24'h000000;
    localparam logic [23:0] IROM_HI   = 24'h00BFFF;
    localparam logic [23:0] INTWIN_LO = 24'h00C000;
    localparam logic [23:0] INTWIN_HI = 24'h00FFFF;
    localparam logic [23:0] RAM_LO    = 24'h00D800;
    localparam logic [23:0] RAM_HI    = 24'h00F7FF;
    localparam logic [23:0] DISP_LO   = 24'h00F800;
    localparam logic [23:0] DISP_HI   = 24'h00FDFF;
    localparam logic [23:0] IO_LO     = 24'h00FF00;
    localparam logic [23:0] IO_HI     = 24'h00FFFF;
    localparam logic [23:0] FONT_LO   = 24'h010000;
    localparam logic [23:0] FONT_HI   = 24'h03FFFF;

    // external windows per boot mode
    localparam logic [23:0] EXTWIN_ROM_LO = 24'h080000;
    localparam logic [23:0] EXTWIN_ROM_HI = 24'h27FFFF;
    localparam logic [23:0] EXTWIN_EXT_LO = 24'h000000;
    localparam logic [23:0] EXTWIN_EXT_HI = 24'h1FFFFF;

    // chip select span of 512k bytes, selected by address bits 22:19
    localparam int CE_SPAN_SHIFT = 19;
    localparam logic [3:0] SPAN_0 = 4'h0;
    localparam logic [3:0] SPAN_1 = 4'h1;
    localparam logic [3:0] SPAN_2 = 4'h2;
    localparam logic [3:0] SPAN_3 = 4'h3;
    localparam logic [3:0] SPAN_4 = 4'h4;

    // program limit in expanded minimum: common area plus one bank
    localparam logic [23:0] COMMON_HI = 24'h007FFF;
    localparam logic [23:0] BANK_SIZE = 24'h008000;

    // all chip selects inactive
    localparam logic [3:0] CE_N_IDLE = 4'hF;

endpackage

// File: cpu_access_if.sv
// cpu access request carried from the top into the decode module
`timescale 1ns/100ps
interface cpu_access_if;
    logic        valid;     // access requested this cycle
    logic        write;     // write when high
    logic        fetch;     // instruction fetch when high
    logic [23:0] addr;      // physical address
    logic        boot_rom;  // latched internal rom boot
    logic [2:0]  mode;      // one-hot bus mode
    logic [7:0]  bank;      // selected program bank, expanded minimum
    logic        go_ext;    // decode: access goes to external bus
    logic [3:0]  ce_n;      // decode: chip selects, active low

    // top drives requests, decoder answers
    modport top (output valid, write, fetch, addr, boot_rom, mode, bank,
                 input go_ext, ce_n);
    modport dec (input valid, write, fetch, addr, boot_rom, mode, bank,
                 output go_ext, ce_n);
endinterface

// File: addr_decode.sv
// combinational address decoder for internal and external routing
`timescale 1ns/100ps
module addr_decode (
    cpu_access_if.dec acc
);

    ////////////////////////////////////////////////////////////////////////
    // true when addr lies in lo..hi inclusive
    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    logic        int_hit;   // address served by internal memory
    logic        win_hit;   // address inside the external window
    logic        prog_ok;   // program fetch allowed in this mode
    logic [3:0]  span;      // 512k span index

    ////////////////////////////////////////////////////////////////////////
    // routing decision
    always_comb begin
        span    = acc.addr[22:19];
        int_hit = in_rng(acc.addr, bus_mode_pkg::INTWIN_LO, bus_mode_pkg::INTWIN_HI);
        // internal rom and font rom stay inside in rom boot
        if (acc.boot_rom) begin
            int_hit = int_hit
                || in_rng(acc.addr, bus_mode_pkg::IROM_LO, bus_mode_pkg::IROM_HI)
                || in_rng(acc.addr, bus_mode_pkg::FONT_LO, bus_mode_pkg::FONT_HI);
        end
        if (acc.boot_rom) begin
            win_hit = in_rng(acc.addr, bus_mode_pkg::EXTWIN_ROM_LO,
                             bus_mode_pkg::EXTWIN_ROM_HI);
        end else begin
            // rom range released to the outside
            win_hit = in_rng(acc.addr, bus_mode_pkg::EXTWIN_EXT_LO,
                             bus_mode_pkg::EXTWIN_EXT_HI);
        end
        // expanded minimum fetches: common area plus one bank only
        prog_ok = 1'b1;
        if (acc.mode == bus_mode_pkg::MODE_EXP_MIN && acc.fetch) begin
            prog_ok = (acc.addr <= bus_mode_pkg::COMMON_HI)
                || (acc.addr[23:15] == {1'b0, acc.bank});
        end
        // internal always wins over overlap; single chip stays inside
        acc.go_ext = acc.valid && win_hit && !int_hit && prog_ok
            && (acc.mode != bus_mode_pkg::MODE_SINGLE_MAX);
        // chip selects 1 to 3 cover one 512k span each, chip select 0 covers spans 0 and 4
        acc.ce_n = bus_mode_pkg::CE_N_IDLE;
        if (acc.go_ext) begin
            if (span == bus_mode_pkg::SPAN_1) begin
                acc.ce_n = 4'hD;
            end else if (span == bus_mode_pkg::SPAN_2) begin
                acc.ce_n = 4'hB;
            end else if (span == bus_mode_pkg::SPAN_3) begin
                acc.ce_n = 4'h7;
            end else if (span == bus_mode_pkg::SPAN_4 || span == bus_mode_pkg::SPAN_0) begin
                acc.ce_n = 4'hE;
            end
        end
    end

endmodule

// File: chip_bus_mode.sv
// chip mode latch, bus mode control and external bus pin driver
//
// Notes on behaviour
// - strap high rom boot, low external boot
// - strap caught when reset releases
// - rom boot: internal rom holds common area
// - internal hits keep strobes and bus idle
// - overlap always goes to internal memory
// - external boot: rom range goes outside
// - three software bus modes
// - single chip refused in external boot
// - single chip: pins become general ports
// - single chip maps only internal ranges
// - expanded modes allowed in either boot
// - rom boot window 080000H to 27FFFFH
// - external boot window 000000H to 1FFFFFH
// - 00C000H to 00FFFFH always internal
// - expanded minimum limits program to bank
// - expanded maximum places program anywhere
// - chip select spans 512k bytes each
// - data pins: ports or data bus
// - rom boot starts with external access off
`timescale 1ns/100ps
module chip_bus_mode (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        boot_source_select_pin, // strap
    input  wire logic        mode_wr,                // software mode write
    input  wire logic [1:0]  mode_req,               // requested mode code
    input  wire logic        bank_wr,                // bank select write
    input  wire logic [7:0]  bank_in,                // program bank
    input  wire logic        cpu_valid,              // cpu access
    input  wire logic        cpu_write,              // write access
    input  wire logic        cpu_program,            // instruction fetch
    input  wire logic [23:0] cpu_addr,               // physical address
    input  wire logic [7:0]  cpu_wdata,              // write data
    input  wire logic [24:0] port_out_data,          // general output ports
    input  wire logic [15:0] port_io_data,           // general io port data
    input  wire logic [15:0] port_io_dir,            // io port direction, 1 out
    input  wire logic [7:0]  data_pin_in,            // data pin level
    output logic             external_memory_boot_mode,
    output logic [2:0]       bus_mode,               // one-hot mode
    output logic             ext_access,             // access went external
    output logic [3:0]       ce_n,                   // chip selects
    output logic             rd_n,                   // read strobe
    output logic             wr_n,                   // write strobe
    output logic [18:0]      addr_out,               // address pins
    output logic [7:0]       data_out,               // data pin drive
    output logic [7:0]       data_oe_n,              // data pin enable, low drives
    output logic [7:0]       rdata,                  // data read from pins
    output logic [5:0]       port_extra_out,         // ports on rd, wr, ce pins
    output logic [7:0]       io_hi_out,              // upper io port drive
    output logic [7:0]       io_hi_oe_n              // upper io port enable
);

    ////////////////////////////////////////////////////////////////////////
    // whole state in one struct
    typedef struct packed {
        logic                  boot_rom;   // latched boot source
        logic                  strap_done; // strap caught since reset
        bus_mode_pkg::bus_mode_t mode;     // current bus mode
        logic [7:0]            bank;       // program bank
        logic                  ext;        // external access flag
        logic [3:0]            ce_n;       // chip select outputs
        logic                  rd_n;       // read strobe
        logic                  wr_n;       // write strobe
        logic [18:0]           addr;       // address pins
        logic [7:0]            dout;       // data pin drive
        logic [7:0]            doe_n;      // data pin enable
        logic [7:0]            rdata;      // captured read data
        logic [5:0]            pext;       // port values on strobe pins
        logic [7:0]            io_hi;      // upper io drive
        logic [7:0]            io_hi_oe_n; // upper io enable
    } state_t;

    state_t state_reg;   // registered state
    state_t state_next;  // next state

    cpu_access_if acc ();  // link to the decoder

    ////////////////////////////////////////////////////////////////////////
    // request into the decoder
    assign acc.valid    = cpu_valid;
    assign acc.write    = cpu_write;
    assign acc.fetch    = cpu_program;
    assign acc.addr     = cpu_addr;
    assign acc.boot_rom = state_reg.boot_rom;
    assign acc.mode     = state_reg.mode;
    assign acc.bank     = state_reg.bank;

    addr_decode u_dec (
        .acc (acc)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        // strap caught on first edge after reset release
        if (!state_reg.strap_done) begin
            state_next.strap_done = 1'b1;
            state_next.boot_rom   = boot_source_select_pin;
        end
        if (mode_wr && state_reg.strap_done) begin
            if (mode_req == bus_mode_pkg::REQ_SINGLE_MAX) begin
                // single chip only when booting from rom
                if (state_reg.boot_rom) begin
                    state_next.mode = bus_mode_pkg::MODE_SINGLE_MAX;
                end
            end else if (mode_req == bus_mode_pkg::REQ_EXP_MIN) begin
                state_next.mode = bus_mode_pkg::MODE_EXP_MIN;
            end else if (mode_req == bus_mode_pkg::REQ_EXP_MAX) begin
                state_next.mode = bus_mode_pkg::MODE_EXP_MAX;
            end
        end
        // external boot cannot stay in single chip
        if (state_reg.strap_done && !state_reg.boot_rom
            && state_reg.mode == bus_mode_pkg::MODE_SINGLE_MAX) begin
            state_next.mode = bus_mode_pkg::MODE_EXP_MAX;
        end
        if (bank_wr) begin
            state_next.bank = bank_in;
        end
        state_next.ext  = acc.go_ext;
        state_next.pext = 6'h00;
        case (state_reg.mode)
            bus_mode_pkg::MODE_SINGLE_MAX: begin
                // all bus pins are general ports
                state_next.ce_n       = port_out_data[24:21];
                state_next.rd_n       = port_out_data[19];
                state_next.wr_n       = port_out_data[20];
                state_next.addr       = port_out_data[18:0];
                state_next.pext       = port_out_data[24:19];
                state_next.dout       = port_io_data[7:0];
                state_next.doe_n      = ~port_io_dir[7:0];
                state_next.io_hi      = port_io_data[15:8];
                state_next.io_hi_oe_n = ~port_io_dir[15:8];
            end
            default: begin
                // idle strobes unless the access went outside
                state_next.ce_n       = acc.ce_n;
                state_next.rd_n       = !(acc.go_ext && !cpu_write);
                state_next.wr_n       = !(acc.go_ext && cpu_write);
                state_next.addr       = cpu_addr[18:0];
                // data pins as the data bus
                state_next.dout       = cpu_wdata;
                state_next.doe_n      = (acc.go_ext && cpu_write) ? 8'h00 : 8'hFF;
                state_next.io_hi      = port_io_data[15:8];
                state_next.io_hi_oe_n = ~port_io_dir[15:8];
            end
        endcase
        // captured read data from the pins
        state_next.rdata = data_pin_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg.boot_rom   <= 1'b1;
            state_reg.strap_done <= 1'b0;
            state_reg.mode       <= bus_mode_pkg::MODE_SINGLE_MAX;
            state_reg.bank       <= 8'h00;
            state_reg.ext        <= 1'b0;
            state_reg.ce_n       <= bus_mode_pkg::CE_N_IDLE;
            state_reg.rd_n       <= 1'b1;
            state_reg.wr_n       <= 1'b1;
            state_reg.addr       <= 19'h00000;
            state_reg.dout       <= 8'h00;
            state_reg.doe_n      <= 8'hFF;
            state_reg.rdata      <= 8'h00;
            state_reg.pext       <= 6'h00;
            state_reg.io_hi      <= 8'h00;
            state_reg.io_hi_oe_n <= 8'hFF;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign external_memory_boot_mode = ~state_reg.boot_rom;
    assign bus_mode       = state_reg.mode;
    assign ext_access     = state_reg.ext;
    assign ce_n           = state_reg.ce_n;
    assign rd_n           = state_reg.rd_n;
    assign wr_n           = state_reg.wr_n;
    assign addr_out       = state_reg.addr;
    assign data_out       = state_reg.dout;
    assign data_oe_n      = state_reg.doe_n;
    assign rdata          = state_reg.rdata;
    assign port_extra_out = state_reg.pext;
    assign io_hi_out      = state_reg.io_hi;
    assign io_hi_oe_n     = state_reg.io_hi_oe_n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence ext_req_s;
        cpu_valid && acc.go_ext;
    endsequence

    intwin_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpu_valid && cpu_addr >= bus_mode_pkg::INTWIN_LO
         && cpu_addr <= bus_mode_pkg::INTWIN_HI
         && state_reg.mode != bus_mode_pkg::MODE_SINGLE_MAX)
        |=> (ce_n == bus_mode_pkg::CE_N_IDLE && rd_n && wr_n))
        else $error("internal window produced external access");

    single_chip_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpu_valid && state_reg.mode == bus_mode_pkg::MODE_SINGLE_MAX) |=> !ext_access)
        else $error("single chip mode went external");

    no_single_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg.strap_done && !state_reg.boot_rom) |=>
        (bus_mode != bus_mode_pkg::MODE_SINGLE_MAX))
        else $error("single chip mode in external boot");

    strobe_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
        ext_req_s |=> (ce_n != bus_mode_pkg::CE_N_IDLE) && (rd_n != wr_n))
        else $error("external access lacks select or strobe");

    strap_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg.strap_done && $stable(state_reg.strap_done))
        |-> $stable(state_reg.boot_rom))
        else $error("boot source changed without reset");

    rom_boot_int_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cpu_valid && state_reg.boot_rom && cpu_addr <= bus_mode_pkg::IROM_HI
         && state_reg.mode != bus_mode_pkg::MODE_SINGLE_MAX)
        |=> (ce_n == bus_mode_pkg::CE_N_IDLE && rd_n && wr_n && !ext_access))
        else $error("internal rom range went external in rom boot");

endmodule

// File: ext_memory_model.sv
// byte-wide external memory standing on the expansion bus
`timescale 1ns/100ps
module ext_memory_model (
    input  wire logic        clk,
    input  wire logic [3:0]  ce_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [18:0] addr_out,
    input  wire logic [7:0]  data_out,
    input  wire logic [7:0]  data_oe_n,
    output logic      [7:0]  data_pin_in
);
    logic [7:0] mem [int];  // sparse store keyed by select and address
    logic [7:0] last_reg;   // pin level of the previous cycle
    int         key;        // current select and address
    assign key = int'({ce_n, addr_out});
    initial last_reg = 8'h5A;
    // vectors and code live here in external boot
    always @(posedge clk) begin
        if (ce_n != 4'hF && !wr_n) begin
            mem[key] = data_out;
        end
        last_reg <= data_pin_in;
    end
    // wire level: device drive, memory drive, else a changing pattern
    always @* begin
        if (data_oe_n == 8'h00) begin
            data_pin_in = data_out;
        end else if (ce_n != 4'hF && !rd_n && mem.exists(key)) begin
            data_pin_in = mem[key];
        end else begin
            data_pin_in = ~last_reg;
        end
    end
endmodule

// File: test_chip_and_bus_mode_address_decode.sv
// self-checking bench for the chip and bus mode decoder
`timescale 1ns/100ps
module test_chip_and_bus_mode_address_decode;
    logic        clk, rst_n, strap, mode_wr, bank_wr, cpu_valid, cpu_write, cpu_program;
    logic [1:0]  mode_req;
    logic [7:0]  bank_in, cpu_wdata, data_pin_in, data_out, data_oe_n, rdata;
    logic [7:0]  io_hi_out, io_hi_oe_n;
    logic [23:0] cpu_addr;
    logic [24:0] port_out_data;
    logic [15:0] port_io_data, port_io_dir;
    logic        ext_boot, ext_access, rd_n, wr_n;
    logic [2:0]  bus_mode;
    logic [3:0]  ce_n;
    logic [18:0] addr_out;
    logic [5:0]  port_extra_out;
    int          n_mismatch, num_checks, cycles;
    int          mode_m;       // model: one-hot bus mode
    logic        boot_rom_m;   // model: latched strap
    logic [7:0]  bank_m;       // model: program bank
    logic [7:0]  exp_mem [int];

    chip_bus_mode DUT (.clk(clk), .rst_n(rst_n), .boot_source_select_pin(strap),
        .mode_wr(mode_wr), .mode_req(mode_req), .bank_wr(bank_wr), .bank_in(bank_in),
        .cpu_valid(cpu_valid), .cpu_write(cpu_write), .cpu_program(cpu_program),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .port_out_data(port_out_data),
        .port_io_data(port_io_data), .port_io_dir(port_io_dir), .data_pin_in(data_pin_in),
        .external_memory_boot_mode(ext_boot), .bus_mode(bus_mode), .ext_access(ext_access),
        .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .addr_out(addr_out), .data_out(data_out),
        .data_oe_n(data_oe_n), .rdata(rdata), .port_extra_out(port_extra_out),
        .io_hi_out(io_hi_out), .io_hi_oe_n(io_hi_oe_n));
    ext_memory_model mem_dev (.clk(clk), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
        .addr_out(addr_out), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_pin_in(data_pin_in));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // compare tasks and model
    task automatic check_val(input string what, input logic [24:0] exp, input logic [24:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bus(input logic [6:0] exp);
        num_checks++;
        if ({ext_access, ce_n, rd_n, wr_n} !== exp) begin
            n_mismatch++;
            $display("ERROR bus_pins expected %h seen %h", exp, {ext_access, ce_n, rd_n, wr_n});
        end
    endtask
    function automatic logic exp_ext(input logic [23:0] a, input logic p);
        logic e;
        if (mode_m == 1 || (a >= 24'h00C000 && a <= 24'h00FFFF)) return 1'b0;
        e = boot_rom_m ? (a >= 24'h080000 && a <= 24'h27FFFF) : (a <= 24'h1FFFFF);
        if (mode_m == 2 && p && a > 24'h007FFF && a[23:15] != {1'b0, bank_m}) e = 1'b0;
        return e;
    endfunction
    // single chip: strobe and select pins carry the general output ports
    function automatic logic [6:0] exp_bus(input logic e, input logic [3:0] ce, input logic w);
        if (mode_m == 1) return {1'b0, port_out_data[24:21], port_out_data[19], port_out_data[20]};
        return {e, ce, ~(e & ~w), ~(e & w)};
    endfunction
    function automatic logic [3:0] exp_ce(input logic [23:0] a);
        case (a[22:19])
            4'h1: return 4'hD;
            4'h2: return 4'hB;
            4'h3: return 4'h7;
            default: return 4'hE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // stimulus tasks, entered at a falling edge
    task automatic access(input logic [23:0] a, input logic w, input logic p);
        logic       e;
        logic [3:0] ce;
        logic [7:0] d;
        int         key;
        e = exp_ext(a, p);
        ce = e ? exp_ce(a) : 4'hF;
        d = 8'($urandom);
        key = int'({ce, a[18:0]});
        cpu_valid = 1'b1;
        cpu_write = w;
        cpu_program = p;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clk);
        check_bus(exp_bus(e, ce, w));
        if (e) check_val("addr_out", 25'(a[18:0]), 25'(addr_out));
        if (mode_m != 1) check_val("data_oe_n", (e && w) ? 25'h0 : 25'hFF, 25'(data_oe_n));
        if (e && w) begin
            exp_mem[key] = d;
            check_val("data_out", 25'(d), 25'(data_out));
        end
        if (e && !w && exp_mem.exists(key)) begin
            @(negedge clk);
            check_val("rdata", 25'(exp_mem[key]), 25'(rdata));
        end
    endtask
    task automatic idle();
        cpu_valid = 1'b0;
        @(negedge clk);
        check_bus(exp_bus(1'b0, 4'hF, 1'b0));
        check_val("port_extra_out", mode_m == 1 ? 25'(port_out_data[24:19]) : 25'h0,
            25'(port_extra_out));
        check_val("io_hi_out", 25'(port_io_data[15:8]), 25'(io_hi_out));
        check_val("io_hi_oe_n", {17'h0, ~port_io_dir[15:8]}, 25'(io_hi_oe_n));
        if (mode_m == 1) begin
            check_val("addr_out", 25'(port_out_data[18:0]), 25'(addr_out));
            check_val("data_out", 25'(port_io_data[7:0]), 25'(data_out));
            check_val("data_oe_n", {17'h0, ~port_io_dir[7:0]}, 25'(data_oe_n));
        end
    endtask
    task automatic set_mode(input logic [1:0] c);
        @(negedge clk);
        mode_wr = 1'b1;
        mode_req = c;
        @(negedge clk);
        mode_wr = 1'b0;
        if (c == 2'h1) mode_m = 2;
        else if (c == 2'h2) mode_m = 4;
        else if (c == 2'h0 && boot_rom_m) mode_m = 1;
        check_val("bus_mode", 25'(mode_m), 25'(bus_mode));
    endtask
    task automatic do_reset(input logic s);
        rst_n = 1'b0;
        strap = s;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        boot_rom_m = s;
        bank_m = 8'h00;
        mode_m = s ? 1 : 4;
        repeat (3) @(negedge clk);
        check_val("boot_mode", 25'(!s), 25'(ext_boot));
        check_val("bus_mode", 25'(mode_m), 25'(bus_mode));
    endtask
    // boundaries of every window, then write and read back
    task automatic run_set(input int n);
        logic [23:0] pts [12] = '{24'h000000, 24'h00BFFF, 24'h00C000, 24'h00D900, 24'h00FFFF,
            24'h010000, 24'h07FFFF, 24'h080000, 24'h1FFFFF, 24'h200000, 24'h27FFFF, 24'h280000};
        foreach (pts[i]) access(pts[i], 1'b0, 1'b0);
        access(24'h080123, 1'b1, 1'b0);
        access(24'h080123, 1'b0, 1'b0);
        access(24'h1A0040, 1'b1, 1'b0);
        access(24'h1A0040, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            access(24'($urandom_range(0, 24'h2FFFFF)), 1'($urandom), 1'($urandom));
        end
        idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, mode_wr, bank_wr, cpu_valid, cpu_write, cpu_program} = 6'h00;
        {strap, mode_req, bank_in, cpu_addr, cpu_wdata} = '0;
        void'($urandom(35586));
        port_out_data = 25'($urandom);
        port_io_data = 16'($urandom);
        port_io_dir = 16'($urandom);
        do_reset(1'b1);
        set_mode(2'h3);
        run_set(20);
        $display("test rom boot single chip done");
        bank_wr = 1'b1;
        bank_in = 8'h11;
        bank_m = 8'h11;
        @(negedge clk);
        bank_wr = 1'b0;
        set_mode(2'h1);
        access(24'h088010, 1'b0, 1'b1);
        access(24'h090010, 1'b0, 1'b1);
        run_set(60);
        $display("test rom boot expanded minimum done");
        set_mode(2'h2);
        run_set(60);
        set_mode(2'h0);
        idle();
        $display("test rom boot expanded maximum done");
        do_reset(1'b0);
        strap = 1'b1;
        repeat (2) @(negedge clk);
        check_val("boot_mode", 25'h1, 25'(ext_boot));
        set_mode(2'h0);
        run_set(60);
        set_mode(2'h1);
        run_set(40);
        $display("test external boot done");
        tally_and_finish();
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
endmodule
